// file: disk_dma_datapath.sv
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - address counter steps two per transfer
// - software loads address counter by write
// - address counter reads back on bus
// - two extension bits count counter carry
// - software writes extension bits directly
// - inhibit bit freezes address counter
// - each disk word advances counters
// - count overflow clears function, sets done
// - go copies function; write requests bus
// - strobe fills buffer, sets buffer full
// - word load requests next memory word
// - match arms load; load moves buffer
// - loaded shifter sets leading control bit
// - write data gated by select, lockout
// - odd word gets trailing parity bit
// - shifts keyed by strobe or track pulse
// - assembled word goes to buffer, bus
// - memory sync clears read buffer full
// - read armed at phase three after match
// - write check compares bits, flags mismatch
// - software writes data buffer directly
// - mismatch error latched until clear
module disk_dma_datapath (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  output logic dma_req_o,
  output logic dma_to_mem_o,
  output logic [17:0] dma_addr_o,
  output logic [15:0] dma_wdata_o,
  input wire logic [15:0] dma_rdata_i,
  input wire logic dma_data_strobe_i,
  input wire logic dma_ssyn_i,
  input wire logic addr_match_i,
  input wire logic control_phase_two_i,
  input wire logic control_phase_three_i,
  input wire logic timing_pulse_two_i,
  input wire logic timing_track_pulse_i,
  input wire logic read_strobe_i,
  input wire logic bit_count_done_i,
  input wire logic read_bit_level_i,
  input wire logic disk_selected_i,
  input wire logic write_lockout_i,
  input wire logic clear_i,
  output logic write_data_o,
  output logic count_done_o
);
  typedef struct packed {
    logic [15:0] memory_address_counter;
    logic [15:0] word_counter;
    logic [15:0] disk_address_reg;
    logic [15:0] data_buffer_reg;
    logic [15:0] rdata;
    logic addr_ext_high;
    logic addr_ext_low;
    logic [1:0] func;
    logic [1:0] word_func;
    logic [1:0] saved_function_bit;
    logic go;
    logic addr_increment_inhibit;
    logic count_done_flag;
    logic compare_mismatch_error;
    logic write_buffer_full;
    logic read_buffer_full;
    logic req;
    logic to_mem;
    logic write_in_progress;
    logic control_bit_flag;
    logic write_bit_reg;
    logic parity;
    logic read_armed;
    logic load_enable;
    logic word_load_flag;
    logic word_assembled_flag;
    logic [4:0] slot;
    logic lock_meta;
    logic lock_sync;
    logic data_out;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic [15:0] shift_data;
  logic shift_load;
  logic shift_pulse;
  logic shift_in;
  logic write_type;
  logic reading;
  logic xfer_done;
  logic cs_write;

  assign write_type = s_q.func == disk_dma_pkg::FUNC_WRITE ||
                      s_q.func == disk_dma_pkg::FUNC_CHECK;
  assign reading = s_q.func == disk_dma_pkg::FUNC_READ;
  assign xfer_done = (dma_data_strobe_i && write_type && s_q.req) ||
                     (dma_ssyn_i && s_q.to_mem && s_q.read_buffer_full);
  assign cs_write = reg_wr_i &&
                    reg_addr_i == disk_dma_pkg::OFF_CONTROL_STATUS;
  assign shift_load = s_q.word_load_flag;
  // strobe for read, track pulse for write
  // a word in flight keeps its mode after the count ends
  assign shift_pulse = s_q.write_in_progress ?
                       (s_q.word_func == disk_dma_pkg::FUNC_WRITE ?
                        timing_track_pulse_i : read_strobe_i) :
                       read_strobe_i && reading;
  assign shift_in = reading ? read_bit_level_i : 1'b0;

  disk_shifter #(
    .WIDTH(disk_dma_pkg::DATA_W)
  ) u_shifter (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .load_i(shift_load),
    .load_data_i(s_q.data_buffer_reg),
    .shift_i(shift_pulse),
    .shift_in_i(shift_in),
    .data_o(shift_data)
  );

  always_comb begin
    logic advance;
    logic [15:0] wc_inc;
    logic [17:0] full_addr;
    advance = 1'b0;
    wc_inc = s_q.word_counter + disk_dma_pkg::COUNT_STEP;
    full_addr = {s_q.addr_ext_high, s_q.addr_ext_low,
                 s_q.memory_address_counter};
    s_d = s_q;
    s_d.word_load_flag = 1'b0;
    s_d.word_assembled_flag = 1'b0;
    s_d.rdata = disk_dma_pkg::WORD_RESET;
    s_d.lock_meta = write_lockout_i;
    s_d.lock_sync = s_q.lock_meta;

    // clear drops latched flags
    // clears first, so that a same-cycle error still lands
    if (clear_i || (cs_write && reg_wdata_i[disk_dma_pkg::CS_CLEAR_BIT])) begin
      s_d.compare_mismatch_error = 1'b0;
      s_d.count_done_flag = 1'b0;
    end

    // step by two per completed transfer
    if (xfer_done && !s_q.addr_increment_inhibit) begin
      full_addr = full_addr + disk_dma_pkg::ADDR_STEP;
      {s_d.addr_ext_high, s_d.addr_ext_low} = full_addr[17:16];
      s_d.memory_address_counter = full_addr[15:0];
    end

    if (dma_data_strobe_i && write_type && s_q.req) begin
      s_d.data_buffer_reg = dma_rdata_i;
      s_d.write_buffer_full = 1'b1;
      s_d.req = 1'b0;
    end

    // sync with data to bus frees buffer
    if (dma_ssyn_i && s_q.to_mem && s_q.read_buffer_full) begin
      s_d.read_buffer_full = 1'b0;
      s_d.req = 1'b0;
    end

    // arm at phase two, fire at pulse two
    if (control_phase_two_i && addr_match_i && write_type &&
        s_q.write_buffer_full && !s_q.write_in_progress) begin
      s_d.load_enable = 1'b1;
    end
    if (timing_pulse_two_i && s_q.load_enable) begin
      s_d.word_load_flag = 1'b1;
      s_d.load_enable = 1'b0;
    end
    if (s_q.word_load_flag) begin
      s_d.write_in_progress = 1'b1;
      s_d.word_func = s_q.func;
      s_d.write_buffer_full = 1'b0;
      s_d.control_bit_flag = 1'b1;
      s_d.slot = '0;
      s_d.parity = 1'b0;
      advance = 1'b1;
      // next word asked for unless last
      s_d.req = wc_inc != disk_dma_pkg::WORD_RESET;
    end

    // bits leave through control flag into write bit
    if (shift_pulse && s_q.write_in_progress) begin
      // parity slot carries the odd-ones fix
      s_d.write_bit_reg = s_q.slot == disk_dma_pkg::SLOT_PARITY ?
                          s_q.parity : s_q.control_bit_flag;
      s_d.control_bit_flag = shift_data[15];
      if (s_q.slot >= disk_dma_pkg::SLOT_FIRST_DATA &&
          s_q.slot < disk_dma_pkg::SLOT_PARITY &&
          s_q.control_bit_flag) begin
        s_d.parity = !s_q.parity;
      end
      if (s_q.word_func == disk_dma_pkg::FUNC_CHECK &&
          s_q.slot < disk_dma_pkg::SLOT_PARITY &&
          s_q.control_bit_flag != read_bit_level_i) begin
        s_d.compare_mismatch_error = 1'b1;
      end
      s_d.slot = s_q.slot + 5'h01;
      if (s_q.slot == disk_dma_pkg::SLOT_END) begin
        s_d.write_in_progress = 1'b0;
        s_d.write_bit_reg = 1'b0;
      end
    end

    // arm reading once the address matched
    if (control_phase_three_i && reading && addr_match_i) begin
      s_d.read_armed = 1'b1;
    end
    // assembled word handed to the bus
    if (bit_count_done_i && control_phase_two_i && reading &&
        s_q.read_armed && !s_q.read_buffer_full &&
        !s_q.word_assembled_flag) begin
      s_d.word_assembled_flag = 1'b1;
    end
    if (s_q.word_assembled_flag) begin
      s_d.data_buffer_reg = shift_data;
      s_d.read_buffer_full = 1'b1;
      s_d.req = 1'b1;
      advance = 1'b1;
    end

    if (advance) begin
      s_d.word_counter = wc_inc;
      s_d.disk_address_reg = s_q.disk_address_reg +
                             disk_dma_pkg::COUNT_STEP;
      if (wc_inc == disk_dma_pkg::WORD_RESET) begin
        s_d.func = disk_dma_pkg::FUNC_NONE;
        s_d.go = 1'b0;
        s_d.count_done_flag = 1'b1;
        s_d.read_armed = 1'b0;
      end
    end

    // software writes override hardware updates
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        disk_dma_pkg::OFF_CONTROL_STATUS: begin
          s_d.saved_function_bit = reg_wdata_i[2:1];
          // extension bits loaded from the bus
          {s_d.addr_ext_high, s_d.addr_ext_low} = reg_wdata_i[5:4];
          // go copies the function bits of the same write; write or check asks bus if buffer empty
          if (reg_wdata_i[disk_dma_pkg::CS_GO_BIT]) begin
            s_d.go = 1'b1;
            s_d.func = reg_wdata_i[2:1];
            s_d.to_mem = reg_wdata_i[2:1] == disk_dma_pkg::FUNC_READ;
            s_d.count_done_flag = 1'b0;
            s_d.read_armed = 1'b0;
            s_d.req = reg_wdata_i[1] && !s_q.write_buffer_full;
          end
        end
        disk_dma_pkg::OFF_WORD_COUNTER: begin
          s_d.word_counter = reg_wdata_i;
        end
        disk_dma_pkg::OFF_MEM_ADDRESS: begin
          s_d.memory_address_counter = reg_wdata_i;
        end
        disk_dma_pkg::OFF_DISK_ADDRESS: begin
          s_d.disk_address_reg = reg_wdata_i;
        end
        disk_dma_pkg::OFF_DISK_ADDRESS_EXT: begin
          s_d.addr_increment_inhibit =
            reg_wdata_i[disk_dma_pkg::DAE_INHIBIT_BIT];
        end
        // direct buffer write checks the path
        disk_dma_pkg::OFF_DATA_BUFFER: begin
          s_d.data_buffer_reg = reg_wdata_i;
        end
        default: begin
        end
      endcase
    end

    if (reg_rd_i) begin
      unique case (reg_addr_i)
        disk_dma_pkg::OFF_CONTROL_STATUS: begin
          s_d.rdata = {1'b0, s_q.compare_mismatch_error,
                       s_q.write_buffer_full, s_q.read_buffer_full,
                       4'h0, s_q.count_done_flag, 1'b0,
                       s_q.addr_ext_high, s_q.addr_ext_low, 1'b0,
                       s_q.func, s_q.go};
        end
        disk_dma_pkg::OFF_WORD_COUNTER: s_d.rdata = s_q.word_counter;
        disk_dma_pkg::OFF_MEM_ADDRESS: begin
          s_d.rdata = s_q.memory_address_counter;
        end
        disk_dma_pkg::OFF_DISK_ADDRESS: begin
          s_d.rdata = s_q.disk_address_reg;
        end
        disk_dma_pkg::OFF_DISK_ADDRESS_EXT: begin
          s_d.rdata = {15'h0000, s_q.addr_increment_inhibit};
        end
        disk_dma_pkg::OFF_DATA_BUFFER: begin
          s_d.rdata = s_q.data_buffer_reg;
        end
        default: s_d.rdata = disk_dma_pkg::WORD_RESET;
      endcase
    end

    s_d.data_out = s_d.write_bit_reg && s_d.write_in_progress &&
                   disk_selected_i && !s_q.lock_sync;
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o = s_q.rdata;
  assign dma_req_o = s_q.req;
  assign dma_to_mem_o = s_q.to_mem;
  assign dma_addr_o = {s_q.addr_ext_high, s_q.addr_ext_low,
                       s_q.memory_address_counter};
  assign dma_wdata_o = s_q.data_buffer_reg;
  assign write_data_o = s_q.data_out;
  assign count_done_o = s_q.count_done_flag;

  default clocking dflt_cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);

  logic mac_wr;
  logic wc_wr;
  assign mac_wr = reg_wr_i && reg_addr_i == disk_dma_pkg::OFF_MEM_ADDRESS;
  assign wc_wr = reg_wr_i && reg_addr_i == disk_dma_pkg::OFF_WORD_COUNTER;

  addr_step_a: assert property (
    xfer_done && !s_q.addr_increment_inhibit && !mac_wr && !cs_write
    |=> dma_addr_o == $past(dma_addr_o) + disk_dma_pkg::ADDR_STEP)
    else $error("address did not step by two");
  addr_load_a: assert property (
    mac_wr |=> s_q.memory_address_counter == $past(reg_wdata_i))
    else $error("address counter not loaded");
  addr_readback_a: assert property (
    reg_rd_i && reg_addr_i == disk_dma_pkg::OFF_MEM_ADDRESS
    |=> reg_rdata_o == $past(s_q.memory_address_counter))
    else $error("address readback wrong");
  ext_write_a: assert property (
    cs_write |=> dma_addr_o[17:16] == $past(reg_wdata_i[5:4]))
    else $error("extension bits not written");
  addr_hold_a: assert property (
    s_q.addr_increment_inhibit && !mac_wr && !cs_write
    |=> $stable(dma_addr_o))
    else $error("inhibited address moved");
  count_step_a: assert property (
    (s_q.word_load_flag || s_q.word_assembled_flag) && !wc_wr
    |=> s_q.word_counter == $past(s_q.word_counter) + 16'h0001)
    else $error("word counter did not advance");
  done_stop_a: assert property (
    s_q.word_load_flag && s_q.word_counter == disk_dma_pkg::COUNT_LAST
    && !reg_wr_i
    |=> count_done_o && s_q.func == disk_dma_pkg::FUNC_NONE && !dma_req_o)
    else $error("overflow did not end block");
  go_write_a: assert property (
    cs_write && reg_wdata_i[2:0] == 3'h3 && !s_q.write_buffer_full
    |=> dma_req_o && s_q.func == disk_dma_pkg::FUNC_WRITE)
    else $error("go with write raised no request");
  buffer_fill_a: assert property (
    dma_data_strobe_i && write_type && s_q.req && !reg_wr_i
    |=> s_q.write_buffer_full && !dma_req_o
        && dma_wdata_o == $past(dma_rdata_i))
    else $error("buffer fill wrong");
  load_move_a: assert property (
    s_q.word_load_flag |=> s_q.write_in_progress
    && !s_q.write_buffer_full && s_q.control_bit_flag
    && shift_data == $past(s_q.data_buffer_reg))
    else $error("word load did not move buffer");
  write_gate_a: assert property (
    write_data_o |-> s_q.write_in_progress && !$past(s_q.lock_sync))
    else $error("write data leaked while gated");
  sync_clear_a: assert property (
    dma_ssyn_i && s_q.to_mem && s_q.read_buffer_full
    && !s_q.word_assembled_flag |=> !s_q.read_buffer_full)
    else $error("read buffer not freed");
  mismatch_set_a: assert property (
    shift_pulse && s_q.write_in_progress
    && s_q.word_func == disk_dma_pkg::FUNC_CHECK
    && s_q.slot < disk_dma_pkg::SLOT_PARITY
    && s_q.control_bit_flag != read_bit_level_i
    |=> s_q.compare_mismatch_error)
    else $error("mismatch not flagged");
  error_hold_a: assert property (
    s_q.compare_mismatch_error && !clear_i && !cs_write
    |=> s_q.compare_mismatch_error)
    else $error("mismatch error dropped");

  word_load_c: cover property (s_q.word_load_flag ##[1:40] write_data_o);
  assembled_c: cover property (s_q.word_assembled_flag ##[1:20] dma_ssyn_i);
  done_c: cover property ($rose(count_done_o));
  check_err_c: cover property ($rose(s_q.compare_mismatch_error));
endmodule // disk_dma_datapath
`default_nettype wire

// file: disk_dma_datapath_tb.sv
`timescale 1ns/1ps
`default_nettype none
module disk_dma_datapath_tb;
  localparam logic [2:0] CS_R = disk_dma_pkg::OFF_CONTROL_STATUS;
  localparam logic [2:0] WC_R = disk_dma_pkg::OFF_WORD_COUNTER;
  localparam logic [2:0] MA_R = disk_dma_pkg::OFF_MEM_ADDRESS;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [2:0] reg_addr_i = 3'h0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic addr_match_i = 1'b0;
  logic control_phase_two_i = 1'b0;
  logic control_phase_three_i = 1'b0;
  logic timing_pulse_two_i = 1'b0;
  logic timing_track_pulse_i = 1'b0;
  logic read_strobe_i = 1'b0;
  logic bit_count_done_i = 1'b0;
  logic read_bit_level_i = 1'b0;
  logic disk_selected_i = 1'b0;
  logic write_lockout_i = 1'b0;
  logic clear_i = 1'b0;
  logic [3:0] mem_wait = 4'h0;
  logic [15:0] reg_rdata_o, dma_wdata_o, dma_rdata_i, rd, w;
  logic [17:0] dma_addr_o;
  logic dma_req_o, dma_to_mem_o, dma_data_strobe_i, dma_ssyn_i;
  logic write_data_o, count_done_o;
  int fail_count = 0;
  int samples_checked = 0;

  always #5 mclk_i = ~mclk_i;

  disk_dma_datapath i_disk_dma_datapath (
    .mclk_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .dma_req_o, .dma_to_mem_o, .dma_addr_o, .dma_wdata_o,
    .dma_rdata_i, .dma_data_strobe_i, .dma_ssyn_i, .addr_match_i,
    .control_phase_two_i, .control_phase_three_i, .timing_pulse_two_i,
    .timing_track_pulse_i, .read_strobe_i, .bit_count_done_i,
    .read_bit_level_i, .disk_selected_i, .write_lockout_i, .clear_i,
    .write_data_o, .count_done_o
  );
  disk_mem_model i_disk_mem_model (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .dma_req_i(dma_req_o),
    .dma_to_mem_i(dma_to_mem_o), .dma_addr_i(dma_addr_o),
    .dma_wdata_i(dma_wdata_o), .wait_i(mem_wait),
    .dma_rdata_o(dma_rdata_i), .dma_data_strobe_o(dma_data_strobe_i),
    .dma_ssyn_o(dma_ssyn_i)
  );

  task automatic report_and_stop();
    $display("compares=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [17:0] got, input logic [17:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reg_write(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic reg_read(input logic [2:0] a);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1;
    rd = reg_rdata_o;
  endtask
  // k: 0 phase two, 1 phase three, 2 pulse two, 3 track, 4 strobe, 5 clear
  task automatic pulse(input int k, input logic lvl);
    @(posedge mclk_i);
    control_phase_two_i <= (k == 0);
    control_phase_three_i <= (k == 1);
    timing_pulse_two_i <= (k == 2);
    timing_track_pulse_i <= (k == 3);
    read_strobe_i <= (k == 4);
    clear_i <= (k == 5);
    read_bit_level_i <= lvl;
    @(posedge mclk_i);
    {control_phase_two_i, control_phase_three_i, timing_pulse_two_i} <= 3'h0;
    {timing_track_pulse_i, read_strobe_i, clear_i} <= 3'h0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // bounded wait; a hang ends the run as a mismatch
  task automatic wait_req(input logic v);
    #1;
    for (int n = 0; n < 100 && dma_req_o !== v; n++) tick(1);
    if (dma_req_o !== v) begin
      fail_count++;
      report_and_stop();
    end
  endtask

  initial begin
    repeat (3) @(posedge mclk_i);
    resetn_i <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      reg_read(a[2:0]);
      chk_word({2'h0, rd}, 18'h0);
    end
    reg_write(3'h7, 16'hffff);
    reg_read(3'h7);
    chk_word({2'h0, rd}, 18'h0);
    reg_write(MA_R, 16'h1234);
    reg_read(MA_R);
    chk_word({2'h0, rd}, 18'h01234);
    reg_write(CS_R, 16'h0030);
    tick(1);
    chk_word(dma_addr_o, 18'h31234);
    reg_write(disk_dma_pkg::OFF_DATA_BUFFER, 16'hbeef);
    tick(1);
    chk_word({2'h0, dma_wdata_o}, 18'h0beef);
    // two-word write starting at memory word 0x10
    reg_write(CS_R, 16'h0000);
    reg_write(WC_R, 16'hfffe);
    reg_write(MA_R, 16'h0020);
    mem_wait <= 4'h3;
    addr_match_i <= 1'b1;
    disk_selected_i <= 1'b1;
    reg_write(CS_R, 16'h0003);
    wait_req(1'b1);
    wait_req(1'b0);
    tick(1);
    chk_word(dma_addr_o, 18'h00022);
    reg_read(CS_R);
    chk_bit(rd[disk_dma_pkg::CS_WBF_BIT], 1'b1);
    tick(4);
    chk_bit(dma_req_o, 1'b0);
    pulse(0, 1'b0);
    pulse(2, 1'b0);
    reg_read(WC_R);
    chk_word({2'h0, rd}, 18'h0ffff);
    reg_read(disk_dma_pkg::OFF_DISK_ADDRESS);
    chk_word({2'h0, rd}, 18'h00001);
    tick(20);
    chk_word(dma_addr_o, 18'h00024);
    w = 16'h1003;
    for (int i = 0; i < 20; i++) begin
      @(posedge mclk_i);
      // deselect for the last data bit only
      disk_selected_i <= (i != 16);
      pulse(3, 1'b0);
      tick(1);
      if (i == 0) chk_bit(write_data_o, 1'b1);
      else if (i == 16) chk_bit(write_data_o, 1'b0);
      else if (i == 17) chk_bit(write_data_o, ^w);
      else if (i == 19) chk_bit(write_data_o, 1'b0);
      else if (i < 16) chk_bit(write_data_o, w[16-i]);
    end
    pulse(0, 1'b0);
    pulse(2, 1'b0);
    tick(2);
    chk_bit(count_done_o, 1'b1);
    reg_read(CS_R);
    chk_word({16'h0, rd[2:1]}, 18'h0);
    tick(10);
    chk_bit(dma_req_o, 1'b0);
    // last word still goes out to the disk
    for (int i = 0; i < 19; i++) pulse(3, 1'b0);
    tick(1);
    chk_bit(write_data_o, 1'b0);
    // one-word read across the address carry
    pulse(5, 1'b0);
    reg_write(CS_R, 16'h0100);
    reg_write(WC_R, 16'hffff);
    reg_write(MA_R, 16'hfffe);
    mem_wait <= 4'h6;
    reg_write(CS_R, 16'h0005);
    pulse(1, 1'b0);
    w = 16'hc5a3;
    for (int i = 15; i >= 0; i--) pulse(4, w[i]);
    bit_count_done_i <= 1'b1;
    pulse(0, 1'b0);
    wait_req(1'b1);
    chk_bit(dma_to_mem_o, 1'b1);
    chk_word({2'h0, dma_wdata_o}, {2'h0, w});
    reg_read(CS_R);
    chk_bit(rd[disk_dma_pkg::CS_RBF_BIT], 1'b1);
    wait_req(1'b0);
    bit_count_done_i <= 1'b0;
    tick(1);
    chk_word({2'h0, i_disk_mem_model.mem_q[8'hff]}, {2'h0, w});
    chk_word(dma_addr_o, 18'h10000);
    reg_read(CS_R);
    chk_bit(rd[disk_dma_pkg::CS_RBF_BIT], 1'b0);
    // write check with inhibit set and a disk stream of zeros
    pulse(5, 1'b0);
    reg_write(CS_R, 16'h0100);
    reg_write(disk_dma_pkg::OFF_DISK_ADDRESS_EXT, 16'h0001);
    reg_write(WC_R, 16'hffff);
    reg_write(MA_R, 16'h0020);
    mem_wait <= 4'h1;
    reg_write(CS_R, 16'h0007);
    wait_req(1'b1);
    wait_req(1'b0);
    tick(1);
    chk_word(dma_addr_o, 18'h00020);
    pulse(0, 1'b0);
    pulse(2, 1'b0);
    pulse(1, 1'b0);
    for (int i = 0; i < 17; i++) pulse(4, 1'b0);
    reg_read(CS_R);
    chk_bit(rd[disk_dma_pkg::CS_ERR_BIT], 1'b1);
    tick(8);
    reg_read(CS_R);
    chk_bit(rd[disk_dma_pkg::CS_ERR_BIT], 1'b1);
    reg_write(CS_R, 16'h0100);
    reg_read(CS_R);
    chk_bit(rd[disk_dma_pkg::CS_ERR_BIT], 1'b0);
    report_and_stop();
  end
endmodule // disk_dma_datapath_tb
`default_nettype wire

// file: disk_dma_pkg.sv
`default_nettype none
package disk_dma_pkg;
  localparam int DATA_W = 16;
  localparam int EXT_W = 2;
  localparam int ADDR_W = DATA_W + EXT_W;
  localparam int REG_ADDR_W = 3;
  localparam int SLOT_W = 5;
  // register indices on the plain register port
  localparam logic [2:0] OFF_CONTROL_STATUS = 3'h0;
  localparam logic [2:0] OFF_WORD_COUNTER = 3'h1;
  localparam logic [2:0] OFF_MEM_ADDRESS = 3'h2;
  localparam logic [2:0] OFF_DISK_ADDRESS = 3'h3;
  localparam logic [2:0] OFF_DISK_ADDRESS_EXT = 3'h4;
  localparam logic [2:0] OFF_DATA_BUFFER = 3'h5;
  // control_status_reg fields
  localparam int CS_GO_BIT = 0;
  localparam int CS_FUNC_LSB = 1;
  localparam int CS_EXT_LSB = 4;
  localparam int CS_DONE_BIT = 7;
  localparam int CS_CLEAR_BIT = 8;
  localparam int CS_RBF_BIT = 12;
  localparam int CS_WBF_BIT = 13;
  localparam int CS_ERR_BIT = 14;
  // disk_address_ext_reg fields
  localparam int DAE_INHIBIT_BIT = 0;
  // function codes
  localparam logic [1:0] FUNC_NONE = 2'h0;
  localparam logic [1:0] FUNC_WRITE = 2'h1;
  localparam logic [1:0] FUNC_READ = 2'h2;
  localparam logic [1:0] FUNC_CHECK = 2'h3;
  // reset values and counts
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [17:0] ADDR_STEP = 18'h00002;
  localparam logic [15:0] COUNT_STEP = 16'h0001;
  localparam logic [15:0] COUNT_LAST = 16'hffff;
  localparam logic [4:0] SLOT_FIRST_DATA = 5'h01;
  localparam logic [4:0] SLOT_PARITY = 5'h11;
  localparam logic [4:0] SLOT_END = 5'h12;
endpackage
`default_nettype wire

// file: disk_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module disk_mem_model (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic dma_req_i,
  input wire logic dma_to_mem_i,
  input wire logic [17:0] dma_addr_i,
  input wire logic [15:0] dma_wdata_i,
  input wire logic [3:0] wait_i,
  output logic [15:0] dma_rdata_o,
  output logic dma_data_strobe_o,
  output logic dma_ssyn_o
);
  logic [15:0] mem_q [256];
  logic [3:0] wait_q;
  logic [1:0] hold_q;
  // word i holds its index over a fixed low byte
  initial begin
    dma_rdata_o = 16'h0000;
    dma_data_strobe_o = 1'b0;
    dma_ssyn_o = 1'b0;
    for (int i = 0; i < 256; i++) begin
      mem_q[i] = {i[7:0], 8'h03};
    end
  end
  always @(posedge mclk_i) begin
    dma_data_strobe_o <= 1'b0;
    dma_ssyn_o <= 1'b0;
    // idle data lines toggle so a stale word never looks valid
    dma_rdata_o <= ~dma_rdata_o;
    if (!resetn_i) begin
      dma_rdata_o <= 16'h0000;
      wait_q <= 4'h0;
      hold_q <= 2'h0;
    end else if (hold_q != 2'h0) begin
      hold_q <= hold_q - 2'h1;
    end else if (dma_req_i && wait_q < wait_i) begin
      wait_q <= wait_q + 4'h1;
    end else if (dma_req_i) begin
      wait_q <= 4'h0;
      // request drops a cycle after service; skip past it
      hold_q <= 2'h2;
      if (dma_to_mem_i) begin
        mem_q[dma_addr_i[8:1]] <= dma_wdata_i;
        dma_ssyn_o <= 1'b1;
      end else begin
        dma_rdata_o <= mem_q[dma_addr_i[8:1]];
        dma_data_strobe_o <= 1'b1;
      end
    end
  end
endmodule // disk_mem_model
`default_nettype wire

// file: disk_shifter.sv
`timescale 1ns/1ps
`default_nettype none
module disk_shifter #(
  parameter int WIDTH = disk_dma_pkg::DATA_W
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic load_i,
  input wire logic [WIDTH-1:0] load_data_i,
  input wire logic shift_i,
  input wire logic shift_in_i,
  output logic [WIDTH-1:0] data_o
);
  typedef struct packed {
    logic [WIDTH-1:0] word;
  } shift_state_t;

  shift_state_t s_q;
  shift_state_t s_d;

  // load wins: a fresh word replaces any half-shifted one
  always_comb begin
    s_d = s_q;
    if (load_i) begin
      s_d.word = load_data_i;
    end else if (shift_i) begin
      s_d.word = {s_q.word[WIDTH-2:0], shift_in_i};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign data_o = s_q.word;
endmodule // disk_shifter
`default_nettype wire
